// File: rtl/pcs_pkg.sv
// constants and types shared by the chip-select port block
package pcs_pkg;

   // ************************************************************
   // register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_EXTRA_IRQ_CONTROL = 8'hc0;
   localparam logic [7:0] IDX_CS_CFG_LOW        = 8'hc2;
   localparam logic [7:0] IDX_CS_CFG_HIGH       = 8'hc3;
   localparam logic [7:0] IDX_PORT_DATA         = 8'hd8;
   localparam logic [7:0] IDX_STROBE_POLARITY   = 8'hae;
   localparam logic [7:0] IDX_BIT_OP            = 8'hf8;
   localparam logic [7:0] IDX_BASE_LO [0:3]     = '{8'h84, 8'h94, 8'hac, 8'hb4};
   localparam logic [7:0] IDX_BASE_HI [0:3]     = '{8'h85, 8'h95, 8'had, 8'hb5};

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int XI_IT_A  = 0;
   localparam int XI_IE_A  = 1;
   localparam int XI_EX_A  = 2;
   localparam int XI_PX_A  = 3;
   localparam int XI_IT_B  = 4;
   localparam int XI_IE_B  = 5;
   localparam int XI_EX_B  = 6;
   localparam int XI_PX_B  = 7;
   localparam int CFG_CMP_LSB    = 0;
   localparam int CFG_FUN_LSB    = 2;
   localparam int CFG_PIN_STRIDE = 4;
   localparam int POL_LSB        = 4;
   localparam int BITOP_VAL_POS  = 8;
   localparam logic [4:0] BITADDR_XCTRL_HI = 5'h18;  // bit addresses c0..c7

   // ************************************************************
   // reset values and fixed codes
   // ************************************************************
   localparam logic [7:0] RST_XCTRL     = 8'h00;
   localparam logic [7:0] RST_CS_CFG    = 8'h00;
   localparam logic [3:0] RST_PORT_DATA = 4'hf;
   localparam logic [3:0] RST_POLARITY  = 4'h0;
   localparam logic [7:0] RST_BASE      = 8'h00;
   localparam logic [7:0] VEC_IRQ_A     = 8'h33;
   localparam logic [7:0] VEC_IRQ_B     = 8'h3b;
   localparam logic [7:0] VEC_NONE      = 8'h00;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;

   // ************************************************************
   // pin function and compare length codes
   // ************************************************************
   typedef enum logic [1:0] {
      PCS_FUN_GPIO = 2'b00,
      PCS_FUN_RD   = 2'b01,
      PCS_FUN_WR   = 2'b10,
      PCS_FUN_RDWR = 2'b11
   } pcs_fun_t;

   typedef enum logic [1:0] {
      PCS_CMP_A15_A0 = 2'b00,
      PCS_CMP_A15_A1 = 2'b01,
      PCS_CMP_A15_A2 = 2'b10,
      PCS_CMP_A15_A8 = 2'b11
   } pcs_cmp_t;

endpackage

// File: rtl/pcs_port.sv
// four-pin chip-select / general I/O port with two extra external interrupts
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - each pin picks one of four modes
// - mode 00 is quasi-bidirectional general I/O
// - pins 2,3 feed extra interrupts in I/O
// - mode 01: read strobe on address match
// - mode 10: write strobe on address match
// - mode 11: read or write strobe
// - each pin has 16-bit base address pair
// - length 00 all bits, 01 ignores A0
// - length 10 ignores A1:A0, 11 compares A15:A8
// - high config: pin3 bits 7:4, pin2 3:0
// - low config: pin1 bits 7:4, pin0 3:0
// - two extra interrupts like core externals
// - interrupt control is bit-addressable at c0
// - per-interrupt high priority bit
// - interrupt taken only while enabled
// - edge mode: pending set, cleared on service
// - trigger bit set falling edge, clear level
// - strobes active low, polarity bit inverts
// - I/O pins driven from port data bits
module pcs_port (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [15:0] xbus_addr,
   input  wire logic        xbus_data_cycle,
   input  wire logic        xbus_rd_n,
   input  wire logic        xbus_wr_n,
   input  wire logic [3:0]  pin_in,
   output logic [3:0]       pin_out,
   output logic [3:0]       pin_oe,
   input  wire logic        irq_a_serviced,
   input  wire logic        irq_b_serviced,
   output logic             irq_a_req,
   output logic             irq_b_req,
   output logic             irq_a_high_priority,
   output logic             irq_b_high_priority,
   output logic [7:0]       irq_vector
);

   // ************************************************************
   // decode helpers
   // ************************************************************

   // word index of an address, with bit 8 set when the address is on the map grid
   function automatic logic [8:0] pcs_decode(input logic [31:0] a);
      logic [8:0] r;
      r = {1'b0, a[9:2]};
      if (a[1:0] == 2'b00 && a[31:10] == 22'h0) begin
         r[8] = 1'b1;
      end
      return r;
   endfunction

   // true when an index names a register of this block
   function automatic logic pcs_mapped(input logic [7:0] idx);
      logic m;
      m = (idx == pcs_pkg::IDX_EXTRA_IRQ_CONTROL) || (idx == pcs_pkg::IDX_CS_CFG_LOW)
          || (idx == pcs_pkg::IDX_CS_CFG_HIGH) || (idx == pcs_pkg::IDX_PORT_DATA)
          || (idx == pcs_pkg::IDX_STROBE_POLARITY) || (idx == pcs_pkg::IDX_BIT_OP);
      for (int i = 0; i < 4; i++) begin
         m = m || (idx == pcs_pkg::IDX_BASE_LO[i]) || (idx == pcs_pkg::IDX_BASE_HI[i]);
      end
      return m;
   endfunction

   // address bits that take part in the compare for each length code
   function automatic logic [15:0] pcs_cmp_mask(input logic [1:0] len);
      logic [15:0] m;
      case (len)
         pcs_pkg::PCS_CMP_A15_A0: m = 16'hffff;
         pcs_pkg::PCS_CMP_A15_A1: m = 16'hfffe;
         pcs_pkg::PCS_CMP_A15_A2: m = 16'hfffc;
         pcs_pkg::PCS_CMP_A15_A8: m = 16'hff00;
         default:                 m = 16'hffff;
      endcase
      return m;
   endfunction

   // ************************************************************
   // register state
   // ************************************************************
   logic [7:0]  cfg_reg [0:1];          // low pins, high pins
   logic [7:0]  base_lo_reg [0:3];
   logic [7:0]  base_hi_reg [0:3];
   logic [3:0]  port_data_reg;
   logic [3:0]  polarity_reg;
   logic [7:0]  xctrl_reg;              // pending bit positions unused here
   logic [1:0]  pending_reg;
   logic [1:0]  src_prev_reg;
   logic [3:0]  pin_out_reg;
   logic [3:0]  pin_oe_reg;
   logic [7:0]  irq_vector_reg;

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   logic        aw_hold_reg;
   logic [31:0] aw_addr_reg;
   logic        w_hold_reg;
   logic [31:0] w_data_reg;
   logic        w_lane0_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        wr_fire;
   logic [8:0]  wr_dec;
   logic [8:0]  rd_dec;
   logic        wr_ok;
   logic        wr_en;
   logic [7:0]  wr_idx;
   logic [7:0]  wr_byte;
   logic [7:0]  rd_byte;

   // handshake readies and response outputs
   assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // write decode once both halves are held
   assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign wr_dec  = pcs_decode(aw_addr_reg);
   assign wr_idx  = wr_dec[7:0];
   assign wr_ok   = wr_dec[8] & pcs_mapped(wr_idx);
   assign wr_en   = wr_fire & wr_ok & w_lane0_reg;   // lane 0 strobe gates every write; the bit-op value rides in bit 8
   assign wr_byte = w_data_reg[7:0];
   assign rd_dec  = pcs_decode(s_axi_araddr);

   // address and data capture, in either order
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 32'h0;
         w_hold_reg  <= 1'b0;
         w_data_reg  <= 32'h0;
         w_lane0_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata;
            w_lane0_reg <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // write response, slverr for unmapped addresses
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= pcs_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_ok ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // read data mux
   always_comb begin
      rd_byte = 8'h00;
      case (rd_dec[7:0])
         pcs_pkg::IDX_EXTRA_IRQ_CONTROL: begin
            rd_byte = xctrl_reg;
            rd_byte[pcs_pkg::XI_IE_A] = pending_reg[0];
            rd_byte[pcs_pkg::XI_IE_B] = pending_reg[1];
         end
         pcs_pkg::IDX_CS_CFG_LOW:      rd_byte = cfg_reg[0];
         pcs_pkg::IDX_CS_CFG_HIGH:     rd_byte = cfg_reg[1];
         pcs_pkg::IDX_PORT_DATA:       rd_byte = {4'h0, pin_in};   // reads pin levels
         pcs_pkg::IDX_STROBE_POLARITY: rd_byte = {polarity_reg, 4'h0};
         default: begin
            for (int i = 0; i < 4; i++) begin
               if (rd_dec[7:0] == pcs_pkg::IDX_BASE_LO[i]) begin
                  rd_byte = base_lo_reg[i];
               end
               if (rd_dec[7:0] == pcs_pkg::IDX_BASE_HI[i]) begin
                  rd_byte = base_hi_reg[i];
               end
            end
         end
      endcase
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= pcs_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= (rd_dec[8] && pcs_mapped(rd_dec[7:0])) ? {24'h0, rd_byte} : 32'h0;
         rresp_reg  <= (rd_dec[8] && pcs_mapped(rd_dec[7:0])) ? pcs_pkg::RESP_OKAY
                                                              : pcs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************

   // mode and compare-length fields, two pins per byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg[0] <= pcs_pkg::RST_CS_CFG;
         cfg_reg[1] <= pcs_pkg::RST_CS_CFG;
      end else if (wr_en && wr_idx == pcs_pkg::IDX_CS_CFG_LOW) begin
         cfg_reg[0] <= wr_byte;
      end else if (wr_en && wr_idx == pcs_pkg::IDX_CS_CFG_HIGH) begin
         cfg_reg[1] <= wr_byte;
      end
   end

   // port data and strobe polarity
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_data_reg <= pcs_pkg::RST_PORT_DATA;
         polarity_reg  <= pcs_pkg::RST_POLARITY;
      end else if (wr_en && wr_idx == pcs_pkg::IDX_PORT_DATA) begin
         port_data_reg <= wr_byte[3:0];
      end else if (wr_en && wr_idx == pcs_pkg::IDX_STROBE_POLARITY) begin
         polarity_reg <= wr_byte[pcs_pkg::POL_LSB +: 4];
      end
   end

   // ************************************************************
   // per-pin address compare and strobe
   // ************************************************************
   logic [1:0] pin_fun [0:3];
   logic [3:0] strobe_on;

   generate
      for (genvar k = 0; k < 4; k++) begin : g_pin
         logic [15:0] base;
         logic [15:0] mask;
         logic        hit;

         // base address pair for this pin
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               base_lo_reg[k] <= pcs_pkg::RST_BASE;
               base_hi_reg[k] <= pcs_pkg::RST_BASE;
            end else if (wr_en && wr_idx == pcs_pkg::IDX_BASE_LO[k]) begin
               base_lo_reg[k] <= wr_byte;
            end else if (wr_en && wr_idx == pcs_pkg::IDX_BASE_HI[k]) begin
               base_hi_reg[k] <= wr_byte;
            end
         end

         // fields sit at the same place within each nibble
         assign pin_fun[k] = cfg_reg[k / 2][(k % 2) * pcs_pkg::CFG_PIN_STRIDE
                                            + pcs_pkg::CFG_FUN_LSB +: 2];
         assign mask = pcs_cmp_mask(cfg_reg[k / 2][(k % 2) * pcs_pkg::CFG_PIN_STRIDE
                                                   + pcs_pkg::CFG_CMP_LSB +: 2]);
         assign base = {base_hi_reg[k], base_lo_reg[k]};
         assign hit  = xbus_data_cycle && (((xbus_addr ^ base) & mask) == 16'h0000);

         // strobe follows the bus strobe chosen by the mode
         always_comb begin
            case (pin_fun[k])
               pcs_pkg::PCS_FUN_RD:   strobe_on[k] = hit & ~xbus_rd_n;
               pcs_pkg::PCS_FUN_WR:   strobe_on[k] = hit & ~xbus_wr_n;
               pcs_pkg::PCS_FUN_RDWR: strobe_on[k] = hit & (~xbus_rd_n | ~xbus_wr_n);
               default:               strobe_on[k] = 1'b0;
            endcase
         end

         // pin driver: quasi-bidirectional drives only a low, strobes drive always
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               pin_out_reg[k] <= 1'b1;
               pin_oe_reg[k]  <= 1'b0;
            end else if (pin_fun[k] == pcs_pkg::PCS_FUN_GPIO) begin
               pin_out_reg[k] <= port_data_reg[k];
               pin_oe_reg[k]  <= ~port_data_reg[k];
            end else begin
               pin_out_reg[k] <= polarity_reg[k] ? strobe_on[k] : ~strobe_on[k];
               pin_oe_reg[k]  <= 1'b1;
            end
         end
      end
   endgenerate

   assign pin_out = pin_out_reg;
   assign pin_oe  = pin_oe_reg;

   // ************************************************************
   // extra interrupt control
   // ************************************************************
   logic       xi_wr_en;
   logic [7:0] xi_wr_val;
   logic       bitop_hit;
   logic [1:0] routed;
   logic [1:0] edge_mode;
   logic [1:0] enabled;
   logic [1:0] src;
   logic [1:0] serviced;
   logic [1:0] sw_pend_wr;
   logic [1:0] sw_pend_val;

   // byte write or single-bit write through the bit-op register
   assign bitop_hit = wr_en && wr_idx == pcs_pkg::IDX_BIT_OP
                      && wr_byte[7:3] == pcs_pkg::BITADDR_XCTRL_HI;
   always_comb begin
      xi_wr_en  = 1'b0;
      xi_wr_val = xctrl_reg;
      xi_wr_val[pcs_pkg::XI_IE_A] = pending_reg[0];
      xi_wr_val[pcs_pkg::XI_IE_B] = pending_reg[1];
      if (wr_en && wr_idx == pcs_pkg::IDX_EXTRA_IRQ_CONTROL) begin
         xi_wr_en  = 1'b1;
         xi_wr_val = wr_byte;
      end else if (bitop_hit) begin
         xi_wr_en  = 1'b1;
         xi_wr_val[wr_byte[2:0]] = w_data_reg[pcs_pkg::BITOP_VAL_POS];
      end
   end

   // priority, enable and trigger-type bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         xctrl_reg <= pcs_pkg::RST_XCTRL;
      end else if (xi_wr_en) begin
         xctrl_reg <= xi_wr_val;
      end
   end

   assign enabled     = {xctrl_reg[pcs_pkg::XI_EX_B], xctrl_reg[pcs_pkg::XI_EX_A]};
   assign edge_mode   = {xctrl_reg[pcs_pkg::XI_IT_B], xctrl_reg[pcs_pkg::XI_IT_A]};
   assign src         = pin_in[3:2];
   assign serviced    = {irq_b_serviced, irq_a_serviced};
   assign sw_pend_wr  = {2{xi_wr_en}};
   assign sw_pend_val = {xi_wr_val[pcs_pkg::XI_IE_B], xi_wr_val[pcs_pkg::XI_IE_A]};
   // a pin reaches its interrupt only in I/O mode with the enable set
   assign routed = enabled & {pin_fun[3] == pcs_pkg::PCS_FUN_GPIO,
                              pin_fun[2] == pcs_pkg::PCS_FUN_GPIO};

   // previous pin level for falling-edge detection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         src_prev_reg <= 2'b11;
      end else begin
         src_prev_reg <= src;
      end
   end

   // pending flags: edge sets win over service and software clears
   generate
      for (genvar j = 0; j < 2; j++) begin : g_irq
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               pending_reg[j] <= 1'b0;
            end else if (!edge_mode[j]) begin
               pending_reg[j] <= routed[j] & ~src[j];
            end else if (routed[j] && src_prev_reg[j] && !src[j]) begin
               pending_reg[j] <= 1'b1;
            end else if (serviced[j]) begin
               pending_reg[j] <= 1'b0;
            end else if (sw_pend_wr[j]) begin
               pending_reg[j] <= sw_pend_val[j];
            end
         end
      end
   endgenerate

   // requests to the interrupt controller
   assign irq_a_req           = pending_reg[0] & enabled[0];
   assign irq_b_req           = pending_reg[1] & enabled[1];
   assign irq_a_high_priority = xctrl_reg[pcs_pkg::XI_PX_A];
   assign irq_b_high_priority = xctrl_reg[pcs_pkg::XI_PX_B];

   // vector of the winning request: high level first, a before b
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_vector_reg <= pcs_pkg::VEC_NONE;
      end else if (irq_a_req && (irq_a_high_priority || !(irq_b_req && irq_b_high_priority))) begin
         irq_vector_reg <= pcs_pkg::VEC_IRQ_A;
      end else if (irq_b_req) begin
         irq_vector_reg <= pcs_pkg::VEC_IRQ_B;
      end else begin
         irq_vector_reg <= pcs_pkg::VEC_NONE;
      end
   end

   assign irq_vector = irq_vector_reg;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_RD_STROBE_PIN0: assert property (
      ((pin_fun[0] == pcs_pkg::PCS_FUN_RD || pin_fun[0] == pcs_pkg::PCS_FUN_RDWR)
       && !polarity_reg[0] && xbus_data_cycle && !xbus_rd_n
       && xbus_addr == {base_hi_reg[0], base_lo_reg[0]})
      |=> (pin_out[0] == 1'b0 && pin_oe[0]))
      else $error("pin0 read strobe missing");

   AST_WR_IDLE_PIN0: assert property (
      (pin_fun[0] == pcs_pkg::PCS_FUN_WR && xbus_wr_n)
      |=> (pin_out[0] == ~$past(polarity_reg[0])))
      else $error("pin0 write strobe active without write");

   AST_NO_STROBE_OFF_CYCLE: assert property (
      (pin_fun[0] != pcs_pkg::PCS_FUN_GPIO && !xbus_data_cycle)
      |=> pin_out[0] == ~$past(polarity_reg[0]))
      else $error("pin0 strobe outside data cycle");

   AST_LEN11_IGNORES_LOW: assert property (
      (pin_fun[0] == pcs_pkg::PCS_FUN_RD && cfg_reg[0][1:0] == pcs_pkg::PCS_CMP_A15_A8
       && xbus_data_cycle && !xbus_rd_n
       && xbus_addr[15:8] == base_hi_reg[0] && polarity_reg[0])
      |=> pin_out[0])
      else $error("pin0 short compare missed");

   AST_GPIO_DRIVE_PIN3: assert property (
      (pin_fun[3] == pcs_pkg::PCS_FUN_GPIO) |=> (pin_oe[3] == ~$past(port_data_reg[3])))
      else $error("pin3 quasi-bidirectional drive wrong");

   AST_EDGE_SETS_PENDING: assert property (
      (edge_mode[0] && routed[0] && src_prev_reg[0] && !src[0]) |=> pending_reg[0])
      else $error("falling edge not latched on irq a");

   AST_SERVICE_CLEARS: assert property (
      (edge_mode[0] && pending_reg[0] && serviced[0] && !xi_wr_en
       && !(routed[0] && src_prev_reg[0] && !src[0]))
      |=> !pending_reg[0])
      else $error("irq a pending not cleared on service");

   AST_LEVEL_TRACKS_PIN: assert property (
      (!edge_mode[1] && routed[1] && !src[1]) |=> pending_reg[1])
      else $error("low level on irq b not pending");

   AST_DISABLED_QUIET: assert property (
      (!enabled[1] && !edge_mode[1]) |=> !pending_reg[1])
      else $error("irq b pending while disabled");

   AST_BVALID_HELD: assert property (
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
      else $error("write response dropped before taken");

endmodule

`default_nettype wire

// File: verification/pcs_periph.sv
// peripheral side model: pulled-up pin wires and a source that pulls them low
`timescale 1ns/1ps
`default_nettype none
module pcs_periph (
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] pull_low,
   output logic [3:0]      pin_in
);
   // wire level: port drive wins, else the outside source, else the pull-up
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         pin_in[k] = pin_oe[k] ? pin_out[k] : !pull_low[k];
      end
   end
endmodule
`default_nettype wire

// File: verification/pcs_port_tb.sv
// self-checking bench for the chip-select port
`timescale 1ns/1ps
`default_nettype none
module pcs_port_tb;
   logic        mclk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic        xdc = 0, xrd_n = 1, xwr_n = 1, sva = 0, svb = 0;
   logic [31:0] aw = 0, wd = 0, ar = 0, rdat;
   logic [15:0] xa = 0;
   logic [3:0]  pin_in, pin_out, pin_oe, pull_low = 0;
   logic [1:0]  bresp, rresp;
   logic        awr, wrd, bv, arr, rv, iqa, iqb, hpa, hpb;
   logic [7:0]  vec;
   int          mismatches = 0, cmp_count = 0, cyc = 0;
   pcs_port uut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .xbus_addr(xa),
      .xbus_data_cycle(xdc), .xbus_rd_n(xrd_n), .xbus_wr_n(xwr_n), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .irq_a_serviced(sva), .irq_b_serviced(svb),
      .irq_a_req(iqa), .irq_b_req(iqb), .irq_a_high_priority(hpa),
      .irq_b_high_priority(hpb), .irq_vector(vec));
   pcs_periph far (.pin_out(pin_out), .pin_oe(pin_oe), .pull_low(pull_low), .pin_in(pin_in));
   // ************
   // bus tasks
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // write: both channels offered, each dropped once taken, bready until bvalid
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      {aw, wd, awv, wv, bry} <= {a, d, 3'b111};
      do begin
         @(posedge mclk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (bv !== 1'b1);
      bry <= 0;
      chk(bresp, 2'b00);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge mclk);
      {ar, arv, rry} <= {a, 2'b11};
      do begin
         @(posedge mclk);
         if (arr) arv <= 0;
      end while (rv !== 1'b1);
      rry <= 0;
      chk(rdat, exp);
      chk(rresp, er);
   endtask
   // one external cycle {data_cycle, rd_n, wr_n}, pin 0 looked at two cycles later
   task automatic bus(input logic [15:0] a, input logic [2:0] c, input logic e);
      @(posedge mclk);
      {xa, xdc, xrd_n, xwr_n} <= {a, c};
      repeat (2) @(posedge mclk);
      chk(pin_out[0], e);
      {xdc, xrd_n, xwr_n} <= 3'b011;
   endtask
   task automatic complete_run;
      if (mismatches == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // clock and hang guard
   initial forever #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
   end
   // main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1;
      rd(32'h360, 32'hf, 2'b00);
      rd(32'h300, 0, 0);
      rd(32'h004, 0, 2'b10);
      wr(32'h210, 32'h34);
      wr(32'h214, 32'h12);
      wr(32'h308, 32'h0a);
      wr(32'h2b8, 32'h10);
      rd(32'h308, 32'h0a, 0);
      bus(16'h1234, 3'b110, 1);
      bus(16'h1237, 3'b110, 1);
      bus(16'h1238, 3'b110, 0);
      bus(16'h1234, 3'b101, 0);
      bus(16'h1234, 3'b010, 0);
      wr(32'h308, 32'h07);
      bus(16'h12ff, 3'b101, 1);
      bus(16'h1334, 3'b101, 0);
      wr(32'h308, 32'h0c);
      bus(16'h1234, 3'b110, 1);
      bus(16'h1234, 3'b101, 1);
      bus(16'h1235, 3'b110, 0);
      wr(32'h308, 32'h0d);
      wr(32'h2b8, 32'h00);
      bus(16'h1235, 3'b110, 0);
      bus(16'h1234, 3'b101, 0);
      bus(16'h1236, 3'b101, 1);
      wr(32'h360, 32'h0d);
      @(posedge mclk);
      chk({pin_oe[1], pin_out[1]}, 2'b10);
      rd(32'h360, 32'h0d, 0);
      wr(32'h3e0, 32'h1c2);
      wr(32'h3e0, 32'h1c0);
      pull_low <= 4'h4;
      repeat (4) @(posedge mclk);
      chk(iqa, 1);
      chk(vec, 8'h33);
      rd(32'h300, 32'h07, 0);
      @(posedge mclk);
      sva <= 1;
      @(posedge mclk);
      sva <= 0;
      @(posedge mclk);
      chk(iqa, 0);
      wr(32'h3e0, 32'h1c3);
      chk(hpa, 1);
      pull_low <= 4'h8;
      repeat (3) @(posedge mclk);
      chk(iqb, 0);
      wr(32'h3e0, 32'h1c6);
      repeat (2) @(posedge mclk);
      chk(iqb, 1);
      chk(vec, 8'h3b);
      wr(32'h3e0, 32'h1c7);
      chk(hpb, 1);
      complete_run();
   end
endmodule
`default_nettype wire
